/* File: tb/tb_gpio_pin_config_port.sv */
// Purpose: self-checking bench for the pin configuration port
// Assumes: zero wait-state slave, hsel and hsize held constant
// Notes: m[] holds each pin's expected readback word
`timescale 1ns/1ps
module tb_gpio_pin_config_port;
    import gpcfg_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0] pins = 8'h00;
    logic [7:0] a;
    logic hrdy;
    logic hresp;
    logic irq;
    gpcfg_padctl_t [7:0] pctl;
    logic [14:0] m [8];
    int num_errors = 0;
    int checks_done = 0;
    int cyc = 0;

    always #25 clk = ~clk;

    gpcfg_port #(.PINS(8)) dut_u (.core_clk_i(clk), .resetn_i(rstn),
        .hsel_i(1'b1), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hrdy), .hrdata_o(hrdata), .hreadyout_o(hrdy),
        .hresp_o(hresp), .pin_in_i(pins), .padctl_o(pctl), .irq_o(irq));

    task automatic final_report();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected %s exp %h got %h", nm, exp, got);
        end
    endtask

    task automatic xfer(logic wr, logic [7:0] ad, logic [31:0] wd);
        htrans <= HTRANS_NONSEQ;
        haddr <= {24'h0, ad};
        hwrite <= wr;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wr ? wd : 32'h0;
        @(posedge clk);
        while (hrdy !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    // mirrors a masked write into the expected per-pin fields
    task automatic cfg(logic [7:0] ad, logic [7:0] msk, logic [6:0] v);
        xfer(1'b1, OFS_MASK, {24'h0, msk});
        xfer(1'b1, ad, {25'h0, v});
        for (int i = 0; i < 8; i++) begin
            if (msk[i] && ad == OFS_DIR) m[i][1:0] = v[1:0];
            if (msk[i] && ad == OFS_SENSE) m[i][6:4] = v[2:0];
            if (msk[i] && ad == OFS_PAD) m[i][14:8] = {v[6:4], 2'h0, v[1:0]};
        end
    endtask

    task automatic rb_all();
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, OFS_SEL, 32'(i));
            xfer(1'b0, OFS_CFGRD, 32'h0);
            chk("readback", rd, {17'h0, m[i]});
        end
    endtask

    task automatic do_reset();
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 8; i++) m[i] = '0;
    endtask

    // legal field value for the chosen register
    function automatic logic [6:0] rnd_val(logic [7:0] ad);
        if (ad == OFS_DIR) return 7'($urandom_range(2));
        if (ad == OFS_SENSE) return 7'($urandom_range(4));
        return {3'($urandom_range(6)), 2'h0, 2'($urandom_range(3))};
    endfunction

    function automatic logic [31:0] pend_bit(logic hit);
        return {31'h0, hit};
    endfunction

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            num_errors++;
            final_report();
        end
    end

    initial begin
        void'($urandom(31103));
        do_reset();
        chk("padctl", {31'h0, |pctl}, 32'h0);
        rb_all();
        cfg(OFS_DIR, 8'h00, 7'h1);
        cfg(OFS_DIR, 8'hFF, 7'h2);
        rb_all();
        repeat (2) @(posedge clk);
        chk("hw_ctrl", {31'h0, pctl[0].hw_ctrl}, 32'h1);
        cfg(OFS_DIR, 8'h80, 7'h0);
        cfg(OFS_PAD, 8'h80, 7'h13);
        repeat (2) @(posedge clk);
        chk("pull_up", {31'h0, pctl[7].pull_up}, 32'h1);
        chk("pull_dn", {31'h0, pctl[7].pull_down}, 32'h0);
        chk("drv_in", 32'(pctl[7].drive), 32'h0);
        cfg(OFS_DIR, 8'h80, 7'h1);
        repeat (2) @(posedge clk);
        chk("drv_out", 32'(pctl[7].drive), 32'h3);
        chk("oe", 32'(pctl[7].oe_allowed), 32'h1);
        xfer(1'b1, 8'h20, 32'hFFFFFFFF);
        xfer(1'b0, 8'h20, 32'h0);
        chk("unmapped", rd, 32'h0);
        chk("hresp", {31'h0, hresp}, 32'h0);
        repeat (3) begin
            repeat (20) begin
                a = 8'h04 + 8'(4 * $urandom_range(2));
                cfg(a, 8'($urandom), rnd_val(a));
            end
            rb_all();
        end
        do_reset();
        rb_all();
        // pin 0 only toggles; inputs stay still while sense changes
        for (int s = 0; s < 5; s++) begin
            cfg(OFS_SENSE, 8'h01, 7'(s));
            repeat (10) @(posedge clk);
            xfer(1'b1, OFS_PEND, 32'hFF);
            pins <= 8'h01;
            repeat (10) @(posedge clk);
            xfer(1'b0, OFS_PEND, 32'h0);
            chk("pend_rise", rd, pend_bit(s != 0));
            chk("irq_rise", {31'h0, irq}, 32'(s != 0));
            xfer(1'b0, OFS_INRAW, 32'h0);
            chk("inraw", rd, 32'h1);
            xfer(1'b1, OFS_PEND, 32'hFF);
            repeat (4) @(posedge clk);
            xfer(1'b0, OFS_PEND, 32'h0);
            chk("pend_hold", rd, pend_bit(s == 4));
            pins <= 8'h00;
            repeat (10) @(posedge clk);
            xfer(1'b0, OFS_PEND, 32'h0);
            chk("pend_fall", rd, pend_bit(s != 1));
            chk("irq_fall", {31'h0, irq}, 32'(s != 1));
            xfer(1'b1, OFS_PEND, 32'hFF);
        end
        final_report();
    end
endmodule

/* File: verilog/gpcfg_pkg.sv */
// Purpose: shared constants and types for the pin configuration port
// Assumes: AHB-Lite slave, 32-bit words, byte addresses
// Notes: register offsets are local choices
package gpcfg_pkg;
    localparam int NPINS = 8;
    localparam int AW = 8;
    // register byte offsets
    localparam logic [7:0] OFS_MASK = 8'h00;
    localparam logic [7:0] OFS_DIR = 8'h04;
    localparam logic [7:0] OFS_SENSE = 8'h08;
    localparam logic [7:0] OFS_PAD = 8'h0C;
    localparam logic [7:0] OFS_SEL = 8'h10;
    localparam logic [7:0] OFS_CFGRD = 8'h14;
    localparam logic [7:0] OFS_PEND = 8'h18;
    localparam logic [7:0] OFS_INRAW = 8'h1C;
    // write data field positions
    localparam int DIR_LSB = 0;
    localparam int SENSE_LSB = 0;
    localparam int DRV_LSB = 0;
    localparam int PAD_LSB = 4;
    localparam int SEL_LSB = 0;
    // readback layout: dir[1:0] sense[6:4] drive[9:8] pad[14:12]
    localparam int RB_DIR = 0;
    localparam int RB_SENSE = 4;
    localparam int RB_DRV = 8;
    localparam int RB_PAD = 12;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum logic [1:0] {
        dir_sw_input, dir_sw_output, dir_hw_controlled, dir_rsvd
    } gpcfg_dir_t;
    typedef enum logic [2:0] {
        sense_falling, sense_rising, sense_both, sense_low, sense_high,
        sense_rsvd5, sense_rsvd6, sense_rsvd7
    } gpcfg_sense_t;
    typedef enum logic [1:0] {
        drive_low, drive_mid, drive_high, drive_high_slew_limited
    } gpcfg_drive_t;
    typedef enum logic [2:0] {
        pad_push_pull, pad_push_pull_pullup, pad_push_pull_pulldown,
        pad_open_drain, pad_open_drain_pullup, pad_open_drain_pulldown,
        pad_analog, pad_rsvd7
    } gpcfg_pad_t;
    typedef struct packed {
        gpcfg_dir_t dir;
        gpcfg_sense_t sense;
        gpcfg_drive_t drive;
        gpcfg_pad_t pad;
    } gpcfg_pin_t;
    // what the pad cell sees for one pin
    typedef struct packed {
        logic oe_allowed;
        logic hw_ctrl;
        logic open_drain;
        logic pull_up;
        logic pull_down;
        logic analog;
        gpcfg_drive_t drive;
    } gpcfg_padctl_t;

    localparam gpcfg_pin_t PIN_RESET = '{dir_sw_input, sense_falling,
                                         drive_low, pad_push_pull};
endpackage

/* File: verilog/gpcfg_port.sv */
// Purpose: configuration of one eight-pin general purpose port
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes: pending flags cleared by writing ones to the pending register
//
// Decided for this implementation: the AHB-Lite slave port and the register addresses.
`timescale 1ns/1ps
module gpcfg_port
    import gpcfg_pkg::*;
#(
    parameter int PINS = NPINS
)(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    input wire logic [PINS-1:0] pin_in_i,
    output gpcfg_pkg::gpcfg_padctl_t [PINS-1:0] padctl_o,
    output logic irq_o
);
    import gpcfg_pkg::*;

    gpcfg_pin_t [PINS-1:0] cfg_q, cfg_d;
    logic [PINS-1:0] mask_q, mask_d, pend_q, pend_d;
    logic [2:0] sel_q, sel_d;
    logic wr_q, wr_d;
    logic [AW-1:0] addr_q, addr_d;
    logic [31:0] rdata_q, rdata_d;
    gpcfg_padctl_t [PINS-1:0] padctl_q, padctl_d;
    logic irq_q, irq_d;
    logic [PINS-1:0] hit, lvl;

    function automatic logic [31:0] readback(gpcfg_pin_t p);
        logic [31:0] r;
        r = '0;
        r[RB_DIR +: 2] = p.dir;
        r[RB_SENSE +: 3] = p.sense;
        r[RB_DRV +: 2] = p.drive;
        r[RB_PAD +: 3] = p.pad;
        return r;
    endfunction

    // only pulls and analog reach an input pad; drive and open-drain wait for any direction other than dir_sw_input
    function automatic gpcfg_padctl_t pad_map(gpcfg_pin_t p);
        gpcfg_padctl_t c;
        logic is_out;
        is_out = (p.dir != dir_sw_input);
        c.oe_allowed = (p.dir == dir_sw_output);
        c.hw_ctrl = (p.dir == dir_hw_controlled);
        c.open_drain = is_out & (p.pad inside {pad_open_drain,
            pad_open_drain_pullup, pad_open_drain_pulldown});
        c.pull_up = p.pad inside {pad_push_pull_pullup,
            pad_open_drain_pullup};
        c.pull_down = p.pad inside {pad_push_pull_pulldown,
            pad_open_drain_pulldown};
        c.analog = (p.pad == pad_analog);
        c.drive = is_out ? p.drive : drive_low;
        return c;
    endfunction

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            gpcfg_sense u_sense (
                .core_clk_i(core_clk_i),
                .resetn_i(resetn_i),
                .pin_i(pin_in_i[g]),
                .sense_i(cfg_q[g].sense),
                .hit_o(hit[g]),
                .level_o(lvl[g])
            );
        end
    endgenerate

    logic take, do_wr;
    assign take = hsel_i & hready_i & (htrans_i == HTRANS_NONSEQ);
    assign do_wr = wr_q;

    always_comb begin
        cfg_d = cfg_q;
        mask_d = mask_q;
        sel_d = sel_q;
        pend_d = pend_q;
        wr_d = take & hwrite_i;
        addr_d = take ? haddr_i[AW-1:0] : addr_q;
        if (do_wr) begin
            unique case (addr_q)
                OFS_MASK: mask_d = hwdata_i[PINS-1:0];
                OFS_SEL: sel_d = hwdata_i[SEL_LSB +: 3];
                OFS_PEND: pend_d = pend_q & ~hwdata_i[PINS-1:0];
                default: ;
            endcase
            for (int i = 0; i < PINS; i++) begin
                if (mask_q[i]) begin
                    unique case (addr_q)
                        OFS_DIR: cfg_d[i].dir =
                            gpcfg_dir_t'(hwdata_i[DIR_LSB +: 2]);
                        OFS_SENSE: cfg_d[i].sense =
                            gpcfg_sense_t'(hwdata_i[SENSE_LSB +: 3]);
                        OFS_PAD: begin
                            cfg_d[i].drive =
                                gpcfg_drive_t'(hwdata_i[DRV_LSB +: 2]);
                            cfg_d[i].pad =
                                gpcfg_pad_t'(hwdata_i[PAD_LSB +: 3]);
                        end
                        default: ;
                    endcase
                end
            end
        end
        // set wins over a same-cycle clear
        pend_d = pend_d | hit;
        irq_d = |pend_d;
        for (int i = 0; i < PINS; i++) begin
            padctl_d[i] = pad_map(cfg_d[i]);
        end
        rdata_d = '0;
        if (take & ~hwrite_i) begin
            unique case (haddr_i[AW-1:0])
                OFS_MASK: rdata_d[PINS-1:0] = mask_d;
                OFS_SEL: rdata_d[SEL_LSB +: 3] = sel_d;
                OFS_CFGRD: rdata_d = readback(cfg_d[sel_d]);
                OFS_PEND: rdata_d[PINS-1:0] = pend_d;
                OFS_INRAW: rdata_d[PINS-1:0] = lvl;
                OFS_DIR: rdata_d[DIR_LSB +: 2] = cfg_d[sel_d].dir;
                OFS_SENSE: rdata_d[SENSE_LSB +: 3] = cfg_d[sel_d].sense;
                OFS_PAD: rdata_d = readback(cfg_d[sel_d]);
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            cfg_q <= {PINS{PIN_RESET}};
            mask_q <= '0;
            sel_q <= '0;
            pend_q <= '0;
            wr_q <= 1'b0;
            addr_q <= '0;
            rdata_q <= '0;
            padctl_q <= {PINS{gpcfg_padctl_t'('0)}};
            irq_q <= 1'b0;
        end else begin
            cfg_q <= cfg_d;
            mask_q <= mask_d;
            sel_q <= sel_d;
            pend_q <= pend_d;
            wr_q <= wr_d;
            addr_q <= addr_d;
            rdata_q <= rdata_d;
            padctl_q <= padctl_d;
            irq_q <= irq_d;
        end
    end

    assign hrdata_o = rdata_q;
    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign padctl_o = padctl_q;
    assign irq_o = irq_q;

    property p_mask_protect;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (do_wr && addr_q == OFS_DIR && !mask_q[0]) |=> $stable(cfg_q[0].dir);
    endproperty
    a_mask_protect: assert property (p_mask_protect)
        else $error("unselected pin changed");

    property p_pend_set;
        @(posedge core_clk_i) disable iff (!resetn_i)
        hit[0] |=> pend_q[0] && irq_q;
    endproperty
    a_pend_set: assert property (p_pend_set)
        else $error("pending flag or irq missing");

    property p_input_no_drive;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (cfg_q[0].dir == dir_sw_input) |->
            (!padctl_q[0].open_drain && padctl_q[0].drive == drive_low);
    endproperty
    a_input_no_drive: assert property (p_input_no_drive)
        else $error("input pad shows output settings");

    property p_reset_cfg;
        @(posedge core_clk_i) !resetn_i |=> cfg_q[0] == PIN_RESET;
    endproperty
    a_reset_cfg: assert property (p_reset_cfg)
        else $error("reset config wrong");

    property p_hw_mode;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (cfg_q[0].dir == dir_hw_controlled) |->
            (padctl_q[0].hw_ctrl && !padctl_q[0].oe_allowed);
    endproperty
    a_hw_mode: assert property (p_hw_mode)
        else $error("hardware mode not shown on pad");

    // a settled rising input must leave a pending flag one edge later
    property p_rise_pend;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (cfg_q[0].sense inside {sense_rising, sense_both} &&
            $rose(lvl[0])) |=> pend_q[0];
    endproperty
    a_rise_pend: assert property (p_rise_pend)
        else $error("rising input left no pending flag");

    property p_low_pend;
        @(posedge core_clk_i) disable iff (!resetn_i)
        (cfg_q[0].sense == sense_low && !lvl[0]) |=> pend_q[0];
    endproperty
    a_low_pend: assert property (p_low_pend)
        else $error("low level left no pending flag");
endmodule

/* File: verilog/gpcfg_sense.sv */
// Purpose: per-pin input synchroniser and interrupt sense detector
// Assumes: pin input is asynchronous to core_clk_i
// Notes: three stages; change counts when stages two and three agree
`timescale 1ns/1ps
module gpcfg_sense
    import gpcfg_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic pin_i,
    input gpcfg_pkg::gpcfg_sense_t sense_i,
    output logic hit_o,
    output logic level_o
);
    logic s1_q, s1_d, s2_q, s2_d, s3_q, s3_d, st_q, st_d, prev_q, prev_d;
    logic hit;

    always_comb begin
        s1_d = pin_i;
        s2_d = s1_q;
        s3_d = s2_q;
        st_d = (s2_q == s3_q) ? s3_q : st_q;
        prev_d = st_q;
    end

    always_ff @(posedge core_clk_i) begin
        if (!resetn_i) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
            st_q <= 1'b0;
            prev_q <= 1'b0;
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            st_q <= st_d;
            prev_q <= prev_d;
        end
    end

    // edges compare with previous sample, levels follow current
    always_comb begin
        unique case (sense_i)
            sense_falling: hit = prev_q & ~st_q;
            sense_rising: hit = ~prev_q & st_q;
            sense_both: hit = prev_q ^ st_q;
            sense_low: hit = ~st_q;
            sense_high: hit = st_q;
            default: hit = 1'b0;
        endcase
    end
    assign hit_o = hit;
    assign level_o = st_q;
endmodule
